// File: core/radio_cfg_pkg.sv
package radio_cfg_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [9:0] IQ_GAIN_TRIM_OFF      = 10'h119;
  localparam logic [9:0] RADIO_BEHAVIOUR_OFF   = 10'h11A;
  localparam logic [9:0] PREAMBLE_TOL_OFF      = 10'h11B;
  localparam logic [9:0] LINE_CODING_OFF       = 10'h11C;
  localparam logic [9:0] RADIO_STATE_OFF       = 10'h1F0;
  localparam logic [9:0] LOCK_TIME_LO_OFF      = 10'h13E;
  localparam logic [9:0] LOCK_TIME_HI_OFF      = 10'h13F;
  localparam int         ADDR_W                = 10;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] IQ_GAIN_TRIM_RST      = 8'h00;
  localparam logic [7:0] RADIO_BEHAVIOUR_RST   = 8'h00;
  localparam logic [7:0] PREAMBLE_TOL_RST      = 8'h00;
  localparam logic [7:0] LINE_CODING_RST       = 8'h00;
  localparam logic [7:0] LOCK_TIME_RST         = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int GAIN_TRIM_MSB        = 6;
  localparam int WAKE_EN_BIT          = 7;
  localparam int IF_CAL_BIT           = 6;
  localparam int WAKE_QUAL_BIT        = 5;
  localparam int SEND_LISTEN_BIT      = 4;
  localparam int LISTEN_SEND_BIT      = 3;
  localparam int CUSTOM_LOCK_BIT      = 2;
  localparam int LNA_EN_BIT           = 1;
  localparam int PA_EN_BIT            = 0;
  localparam int PREAMBLE_TOL_MSB     = 3;
  localparam int BIPHASE_BIT          = 6;
  localparam int CHECKSUM_BIT         = 5;
  localparam int BLOCK_CODE_BIT       = 4;
  localparam int WHITEN_BIT           = 3;
  localparam int SYMBOL_LEN_MSB       = 2;

  // ------------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------------
  localparam logic [3:0] PREAMBLE_EXACT   = 4'hC;
  localparam logic [3:0] PREAMBLE_LOOSEST = 4'h8;
  localparam logic [3:0] PREAMBLE_OFF     = 4'h0;
  localparam logic [2:0] SYMBOL_8BIT      = 3'h0;
  localparam logic [2:0] SYMBOL_10BIT     = 3'h1;
  localparam logic [3:0] PAIRS_PER_WINDOW = 4'hC;

  // ------------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------------
  localparam int         CLK_MHZ            = 200;
  localparam int         DEFAULT_LOCK_US    = 1;
  localparam logic [15:0] DEFAULT_LOCK_CYC  =
    16'(DEFAULT_LOCK_US * CLK_MHZ);
  localparam logic [15:0] CUSTOM_LOCK_SCALE = 16'h0001;
  localparam logic [7:0]  IF_CAL_CYC        = 8'h40;

  typedef enum logic [2:0] {
    RADIO_SLEEP,
    RADIO_OFF,
    RADIO_ON,
    RADIO_RX,
    RADIO_TX
  } radio_state_t;

endpackage

// File: core/radio_cfg_reg.sv
module radio_cfg_reg
  import radio_cfg_pkg::*;
#(
  parameter logic [9:0] ADDR  = 10'h000,
  parameter logic [7:0] RST   = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  output logic      [7:0] o_value
);

  typedef struct packed {
    logic [7:0] value;
  } reg_state_t;

  reg_state_t st;
  reg_state_t next_st;

  always_comb begin
    next_st = st;
    if (i_wr && i_addr == ADDR) begin
      next_st.value = i_wdata & WMASK;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st.value <= RST;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_value = st.value;

endmodule

// File: core/radio_cfg_timer.sv
module radio_cfg_timer
  import radio_cfg_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_start,
  input  wire logic [15:0] i_count,
  output logic             o_busy,
  output logic             o_done
);

  typedef struct packed {
    logic [15:0] left;
    logic        busy;
    logic        done;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (i_start) begin
      next_st.left = (i_count == 16'h0000) ? 16'h0001 : i_count;
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      next_st.left = st.left - 16'h0001;
      if (st.left == 16'h0001) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_busy = st.busy;
  assign o_done = st.done;

endmodule

// File: core/radio_mode_and_coding_config.sv
// The address-and-strobe port was chosen for this implementation.
module radio_mode_and_coding_config
  import radio_cfg_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_power_up,
  input  wire logic       i_power_down,
  input  wire logic       i_sleep,
  input  wire logic       i_packet_mode,
  input  wire logic       i_tx_request,
  input  wire logic       i_rx_request,
  input  wire logic       i_tx_packet_done,
  input  wire logic       i_rx_packet_valid,
  input  wire logic       i_wake_event,
  input  wire logic       i_signal_strong,
  output logic      [7:0] o_rdata,
  output logic      [6:0] o_iq_gain_trim,
  output logic            o_if_cal_active,
  output logic            o_synth_locking,
  output logic            o_wake_active,
  output logic            o_wake_qualified,
  output logic      [2:0] o_radio_state,
  output logic            o_test_pin_lna,
  output logic            o_test_pin_lna_oe_n,
  output logic            o_test_pin_pa,
  output logic            o_test_pin_pa_oe_n,
  output logic      [3:0] o_preamble_errors_max,
  output logic            o_preamble_detect_en,
  output logic            o_biphase_coding_enable,
  output logic            o_custom_checksum_select,
  output logic            o_block_code_enable,
  output logic            o_whitening_enable,
  output logic            o_symbol_10bit
);

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic [7:0] iq_gain_trim;
  logic [7:0] radio_behaviour_flags;
  logic [7:0] preamble_error_tolerance;
  logic [7:0] line_coding_options;
  logic [7:0] lock_time_lo;
  logic [7:0] lock_time_hi;

  radio_cfg_reg #(
    .ADDR  (IQ_GAIN_TRIM_OFF),
    .RST   (IQ_GAIN_TRIM_RST),
    .WMASK (8'h7F)
  ) u_gain (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .o_value   (iq_gain_trim)
  );

  radio_cfg_reg #(
    .ADDR  (RADIO_BEHAVIOUR_OFF),
    .RST   (RADIO_BEHAVIOUR_RST),
    .WMASK (8'hFF)
  ) u_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .o_value   (radio_behaviour_flags)
  );

  radio_cfg_reg #(
    .ADDR  (PREAMBLE_TOL_OFF),
    .RST   (PREAMBLE_TOL_RST),
    .WMASK (8'h0F)
  ) u_pre (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .o_value   (preamble_error_tolerance)
  );

  radio_cfg_reg #(
    .ADDR  (LINE_CODING_OFF),
    .RST   (LINE_CODING_RST),
    .WMASK (8'h7F)
  ) u_code (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .o_value   (line_coding_options)
  );

  radio_cfg_reg #(
    .ADDR  (LOCK_TIME_LO_OFF),
    .RST   (LOCK_TIME_RST),
    .WMASK (8'hFF)
  ) u_lock_lo (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .o_value   (lock_time_lo)
  );

  radio_cfg_reg #(
    .ADDR  (LOCK_TIME_HI_OFF),
    .RST   (LOCK_TIME_RST),
    .WMASK (8'hFF)
  ) u_lock_hi (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .o_value   (lock_time_hi)
  );

  // ------------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------------
  logic        cal_start;
  logic        cal_busy;
  logic        lock_start;
  logic        lock_busy;
  logic        lock_done;
  logic [15:0] lock_count;

  always_comb begin
    if (radio_behaviour_flags[CUSTOM_LOCK_BIT]) begin
      lock_count = 16'({lock_time_hi, lock_time_lo} *
                       CUSTOM_LOCK_SCALE);
    end else begin
      lock_count = DEFAULT_LOCK_CYC;
    end
  end

  radio_cfg_timer u_cal (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_start   (cal_start),
    .i_count   ({8'h00, IF_CAL_CYC}),
    .o_busy    (cal_busy),
    .o_done    ()
  );

  radio_cfg_timer u_lock (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_start   (lock_start),
    .i_count   (lock_count),
    .o_busy    (lock_busy),
    .o_done    (lock_done)
  );

  // ------------------------------------------------------------------
  // Radio state and outputs
  // ------------------------------------------------------------------
  typedef struct packed {
    radio_state_t state;
    radio_state_t target;
    logic [7:0]   rdata;
    logic         lna;
    logic         lna_oe_n;
    logic         pa;
    logic         pa_oe_n;
    logic         wake_active;
    logic         wake_qualified;
    logic         cal_active;
    logic         locking;
    logic [6:0]   gain;
    logic [3:0]   pre_max;
    logic         pre_en;
    logic         biphase;
    logic         checksum;
    logic         block;
    logic         whiten;
    logic         sym10;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  logic [7:0] state_code;
  logic       auto_ok;
  logic [3:0] pre_field;

  assign state_code = {5'h00, st.state};
  assign auto_ok    = i_packet_mode;
  assign pre_field  = preamble_error_tolerance[PREAMBLE_TOL_MSB:0];
  assign cal_start  = i_ce && st.state == RADIO_OFF && i_power_up &&
                      radio_behaviour_flags[IF_CAL_BIT];
  assign lock_start = i_ce && next_st.target != st.target &&
                      (next_st.target == RADIO_RX ||
                       next_st.target == RADIO_TX);

  always_comb begin
    next_st       = st;
    next_st.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        IQ_GAIN_TRIM_OFF:    next_st.rdata = iq_gain_trim;
        RADIO_BEHAVIOUR_OFF: next_st.rdata = radio_behaviour_flags;
        PREAMBLE_TOL_OFF:    next_st.rdata = preamble_error_tolerance;
        LINE_CODING_OFF:     next_st.rdata = line_coding_options;
        LOCK_TIME_LO_OFF:    next_st.rdata = lock_time_lo;
        LOCK_TIME_HI_OFF:    next_st.rdata = lock_time_hi;
        RADIO_STATE_OFF:     next_st.rdata = state_code;
        default:             next_st.rdata = 8'h00;
      endcase
    end
    unique case (st.state)
      RADIO_SLEEP: begin
        if (!i_sleep) begin
          next_st.state = RADIO_OFF;
        end
      end
      RADIO_OFF: begin
        if (i_power_up) begin
          next_st.state = RADIO_ON;
        end
      end
      RADIO_ON: begin
        if (i_tx_request) begin
          next_st.target = RADIO_TX;
        end else if (i_rx_request) begin
          next_st.target = RADIO_RX;
        end
      end
      RADIO_RX: begin
        if (i_rx_packet_valid && auto_ok &&
            radio_behaviour_flags[LISTEN_SEND_BIT]) begin
          next_st.target = RADIO_TX;
        end else if (i_tx_request) begin
          next_st.target = RADIO_TX;
        end
      end
      RADIO_TX: begin
        if (i_tx_packet_done && auto_ok &&
            radio_behaviour_flags[SEND_LISTEN_BIT]) begin
          next_st.target = RADIO_RX;
        end else if (i_tx_packet_done) begin
          next_st.target = RADIO_ON;
          next_st.state  = RADIO_ON;
        end else if (i_rx_request) begin
          next_st.target = RADIO_RX;
        end
      end
      default: next_st.state = RADIO_OFF;
    endcase
    if (lock_done) begin
      next_st.state = st.target;
    end
    if (i_power_down) begin
      next_st.state  = RADIO_OFF;
      next_st.target = RADIO_OFF;
    end
    if (i_sleep) begin
      next_st.state  = RADIO_SLEEP;
      next_st.target = RADIO_SLEEP;
    end
    next_st.cal_active     = cal_busy || cal_start;
    next_st.locking        = lock_busy;
    next_st.wake_active    = radio_behaviour_flags[WAKE_EN_BIT];
    next_st.wake_qualified = radio_behaviour_flags[WAKE_EN_BIT] &&
                             i_wake_event &&
                             (!radio_behaviour_flags[WAKE_QUAL_BIT] ||
                              i_signal_strong);
    next_st.lna_oe_n = !(radio_behaviour_flags[LNA_EN_BIT] &&
                         next_st.state != RADIO_SLEEP);
    next_st.lna      = radio_behaviour_flags[LNA_EN_BIT] &&
                       next_st.state == RADIO_RX;
    next_st.pa_oe_n  = !(radio_behaviour_flags[PA_EN_BIT] &&
                         next_st.state != RADIO_SLEEP);
    next_st.pa       = radio_behaviour_flags[PA_EN_BIT] &&
                       next_st.state == RADIO_TX;
    next_st.gain     = iq_gain_trim[GAIN_TRIM_MSB:0];
    if (pre_field >= PREAMBLE_LOOSEST && pre_field <= PREAMBLE_EXACT) begin
      next_st.pre_en  = 1'b1;
      next_st.pre_max = PAIRS_PER_WINDOW - pre_field;
    end else if (pre_field == PREAMBLE_OFF) begin
      next_st.pre_en  = 1'b0;
      next_st.pre_max = 4'h0;
    end else begin
      next_st.pre_en  = 1'b1;
      next_st.pre_max = 4'h0;
    end
    next_st.biphase  = line_coding_options[BIPHASE_BIT];
    next_st.checksum = line_coding_options[CHECKSUM_BIT];
    next_st.block    = line_coding_options[BLOCK_CODE_BIT];
    next_st.whiten   = line_coding_options[WHITEN_BIT];
    next_st.sym10    = line_coding_options[SYMBOL_LEN_MSB:0] ==
                       SYMBOL_10BIT;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st <= '{state: RADIO_OFF, target: RADIO_OFF, lna_oe_n: 1'b1,
              pa_oe_n: 1'b1, default: '0};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Output ports
  // ------------------------------------------------------------------

  assign o_rdata                  = st.rdata;
  assign o_iq_gain_trim           = st.gain;
  assign o_if_cal_active          = st.cal_active;
  assign o_synth_locking          = st.locking;
  assign o_wake_active            = st.wake_active;
  assign o_wake_qualified         = st.wake_qualified;
  assign o_radio_state            = st.state;
  assign o_test_pin_lna           = st.lna;
  assign o_test_pin_lna_oe_n      = st.lna_oe_n;
  assign o_test_pin_pa            = st.pa;
  assign o_test_pin_pa_oe_n       = st.pa_oe_n;
  assign o_preamble_errors_max    = st.pre_max;
  assign o_preamble_detect_en     = st.pre_en;
  assign o_biphase_coding_enable  = st.biphase;
  assign o_custom_checksum_select = st.checksum;
  assign o_block_code_enable      = st.block;
  assign o_whitening_enable       = st.whiten;
  assign o_symbol_10bit           = st.sym10;

endmodule

// File: verification/radio_cfg_assertions.sv
module radio_cfg_checker
  import radio_cfg_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  input  wire logic [6:0] o_iq_gain_trim,
  input  wire logic       o_wake_active,
  input  wire logic [2:0] o_radio_state,
  input  wire logic       o_test_pin_lna,
  input  wire logic       o_test_pin_lna_oe_n,
  input  wire logic       o_test_pin_pa,
  input  wire logic       o_test_pin_pa_oe_n,
  input  wire logic [3:0] o_preamble_errors_max,
  input  wire logic       o_preamble_detect_en,
  input  wire logic       o_biphase_coding_enable,
  input  wire logic       o_custom_checksum_select,
  input  wire logic       o_block_code_enable,
  input  wire logic       o_whitening_enable,
  input  wire logic       o_symbol_10bit
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic mapped;
  assign mapped = i_addr inside {[10'h119:10'h11C], 10'h13E, 10'h13F,
                                 10'h1F0};
  function automatic logic [3:0] perr(logic [3:0] v);
    return (v >= 4'h8 && v <= 4'hC) ? 4'hC - v : 4'h0;
  endfunction
  sequence wr_at(logic [9:0] a);
    i_wr && i_addr == a ##1 !(i_wr && i_addr == a);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_unmapped_zero: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_gain_copy: assert property (wr_at(IQ_GAIN_TRIM_OFF) |=>
    o_iq_gain_trim == $past(i_wdata[6:0], 2))
    else $error("gain trim output wrong");
  a_wake_flag: assert property (wr_at(RADIO_BEHAVIOUR_OFF) |=>
    o_wake_active == $past(i_wdata[7], 2))
    else $error("wake enable output wrong");
  a_pin_enables: assert property (wr_at(RADIO_BEHAVIOUR_OFF) |=>
    {o_test_pin_lna_oe_n, o_test_pin_pa_oe_n} == ~$past(i_wdata[1:0], 2))
    else $error("pin enables wrong");
  a_lna_rx: assert property (!o_test_pin_lna_oe_n &&
    $past(!o_test_pin_lna_oe_n) && $stable(o_radio_state) |->
    o_test_pin_lna == (o_radio_state == RADIO_RX))
    else $error("lna pin does not follow receive state");
  a_pa_tx: assert property (!o_test_pin_pa_oe_n &&
    $past(!o_test_pin_pa_oe_n) && $stable(o_radio_state) |->
    o_test_pin_pa == (o_radio_state == RADIO_TX))
    else $error("pa pin does not follow transmit state");
  a_coding_bits: assert property (wr_at(LINE_CODING_OFF) |=>
    {o_biphase_coding_enable, o_custom_checksum_select,
     o_block_code_enable, o_whitening_enable} == $past(i_wdata[6:3], 2)
    && o_symbol_10bit == ($past(i_wdata[2:0], 2) == SYMBOL_10BIT))
    else $error("line coding outputs wrong");
  a_preamble_map: assert property (wr_at(PREAMBLE_TOL_OFF) |=>
    o_preamble_detect_en == ($past(i_wdata[3:0], 2) != 4'h0) &&
    o_preamble_errors_max == perr($past(i_wdata[3:0], 2)))
    else $error("preamble tolerance outputs wrong");
  c_tx: cover property (o_radio_state == RADIO_TX);
  c_rx: cover property (o_radio_state == RADIO_RX);
  c_coding: cover property (wr_at(LINE_CODING_OFF));
endmodule

bind radio_mode_and_coding_config radio_cfg_checker chk_i (
  .i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .o_iq_gain_trim, .o_wake_active, .o_radio_state, .o_test_pin_lna,
  .o_test_pin_lna_oe_n, .o_test_pin_pa, .o_test_pin_pa_oe_n,
  .o_preamble_errors_max, .o_preamble_detect_en,
  .o_biphase_coding_enable, .o_custom_checksum_select,
  .o_block_code_enable, .o_whitening_enable, .o_symbol_10bit
);

// File: verification/radio_mode_and_coding_config_tb_top.sv
module radio_mode_and_coding_config_tb_top
  import radio_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [1:0] wake = 2'h0;
  logic [7:0] rdata;
  logic [6:0] gain;
  logic [2:0] st;
  logic [3:0] perr;
  logic       cal, lock, wk, wq, lna, lna_oe_n, pa, pa_oe_n;
  logic       pdet, bip, crc, blk, wht, sym10;
  int         fails = 0;
  int         compares = 0;
  int         cyc = 0;
  int         n;
  int         mdl[int];
  int         regs[6] = '{'h119, 'h11A, 'h11B, 'h11C, 'h13E, 'h13F};
  int         pv[6] = '{0, 8, 9, 10, 11, 12};
  logic [31:0] v;

  always #2.5 clk = ~clk;

  radio_mode_and_coding_config radio_mode_and_coding_config_i (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_power_up(ev[0]),
    .i_power_down(ev[1]), .i_sleep(ev[7]), .i_packet_mode(ev[2]),
    .i_tx_request(ev[3]), .i_rx_request(ev[4]),
    .i_tx_packet_done(ev[5]), .i_rx_packet_valid(ev[6]),
    .i_wake_event(wake[0]), .i_signal_strong(wake[1]),
    .o_rdata(rdata), .o_iq_gain_trim(gain), .o_if_cal_active(cal),
    .o_synth_locking(lock), .o_wake_active(wk), .o_wake_qualified(wq),
    .o_radio_state(st), .o_test_pin_lna(lna),
    .o_test_pin_lna_oe_n(lna_oe_n), .o_test_pin_pa(pa),
    .o_test_pin_pa_oe_n(pa_oe_n), .o_preamble_errors_max(perr),
    .o_preamble_detect_en(pdet), .o_biphase_coding_enable(bip),
    .o_custom_checksum_select(crc), .o_block_code_enable(blk),
    .o_whitening_enable(wht), .o_symbol_10bit(sym10)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [7:0] wmask(int a);
    case (a)
      'h119, 'h11C: return 8'h7F;
      'h11B: return 8'h0F;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic logic [4:0] pexp(int p);
    return {p != 0, (p >= 8 && p <= 12) ? 4'(12 - p) : 4'h0};
  endfunction

  task automatic wreg(logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    mdl[a] = int'(d & wmask(a));
  endtask

  task automatic rreg(logic [9:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, 16'(mdl.exists(a) ? mdl[a] : 0));
  endtask

  task automatic pulse(int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask

  task automatic wait_st(logic [2:0] s, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (st !== s && c < 1000);
    chk("state", st, s);
  endtask

  task automatic pins(logic [3:0] e);
    repeat (2) @(negedge clk);
    chk("pins", {lna, lna_oe_n, pa, pa_oe_n}, e);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    void'($urandom(92));
    foreach (regs[i]) mdl[regs[i]] = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("rst_state", st, RADIO_OFF);
    chk("rst_oe", {lna_oe_n, pa_oe_n}, 2'b11);
    for (int r = 0; r < 6; r++) begin
      v = $urandom();
      @(posedge clk);
      wake <= v[1:0];
      wreg(IQ_GAIN_TRIM_OFF, v[7:0] & 8'h7F);
      wreg(RADIO_BEHAVIOUR_OFF, v[15:8]);
      wreg(PREAMBLE_TOL_OFF, 8'(pv[r]));
      wreg(LINE_CODING_OFF, {1'b0, v[22:19], 2'b00, r[0]});
      wreg(LOCK_TIME_LO_OFF, v[31:24]);
      repeat (2) @(negedge clk);
      chk("gain", gain, 16'(mdl['h119]));
      chk("wake", wk, 16'(mdl['h11A] >> 7));
      chk("wake_q", wq, 16'(v[15] && v[0] && (!v[13] || v[1])));
      chk("coding", {bip, crc, blk, wht},
          16'(mdl['h11C] >> 3));
      chk("sym10", sym10, 16'(r[0]));
      chk("preamble", {pdet, perr}, pexp(pv[r]));
      foreach (regs[i]) rreg(10'(regs[i]));
      rreg(10'h11D);
    end
    wreg(LOCK_TIME_LO_OFF, 8'h14);
    wreg(LOCK_TIME_HI_OFF, 8'h00);
    wreg(RADIO_BEHAVIOUR_OFF, 8'h53);
    pulse(0);
    repeat (2) @(negedge clk);
    chk("cal_on", cal, 1'b1);
    wait_st(RADIO_ON, n);
    pins(4'b0000);
    pulse(3);
    repeat (2) @(negedge clk);
    chk("locking", lock, 1'b1);
    wait_st(RADIO_TX, n);
    chk("lock_def", 16'(n >= int'(DEFAULT_LOCK_CYC) &&
        n <= int'(DEFAULT_LOCK_CYC) + 8), 1'b1);
    chk("lock_end", lock, 1'b0);
    pins(4'b0010);
    @(posedge clk);
    ev[2] <= 1'b1;
    pulse(5);
    wait_st(RADIO_RX, n);
    pins(4'b1000);
    mdl['h1F0] = int'(RADIO_RX);
    rreg(RADIO_STATE_OFF);
    wreg(RADIO_BEHAVIOUR_OFF, 8'h0F);
    pulse(6);
    wait_st(RADIO_TX, n);
    chk("lock_cust", 16'(n >= 20 && n <= 28), 1'b1);
    wreg(RADIO_BEHAVIOUR_OFF, 8'h00);
    pins(4'b0101);
    pulse(5);
    repeat (300) @(negedge clk);
    chk("no_turn", st, RADIO_ON);
    pulse(1);
    wait_st(RADIO_OFF, n);
    pulse(0);
    repeat (2) @(negedge clk);
    chk("cal_off", cal, 1'b0);
    wreg(RADIO_BEHAVIOUR_OFF, 8'h03);
    repeat (2) @(posedge clk);
    ev[7] <= 1'b1;
    pins(4'b0101);
    chk("sleep", st, RADIO_SLEEP);
    test_done();
  end
endmodule
